/* rtl/shp_defs.svh */
/*
 * Constants for the host serial port block: SPI framing, serial-mode codes
 * and transparent-mode packetization triggers.
 * Assumes inclusion by bare name from rtl/ files only.
 */
`ifndef SHP_DEFS_SVH
`define SHP_DEFS_SVH

// Frame start delimiter of the unescaped framed format
`define SHP_FRAME_START 8'h7e
// Header bytes after the delimiter: length high, length low
`define SHP_HDR_LEN 2'h2
// Checksum byte that follows the payload
`define SHP_CSUM_LEN 16'h0001
// Byte width and index of the first (most significant) bit
`define SHP_BYTE_W 8
`define SHP_MSB 3'h7
// Largest radio payload that triggers packetization
`define SHP_MAX_PAYLOAD 7'h64
// Idle-gap timeout of zero means packetize at once
`define SHP_RO_ZERO 8'h00
// Idle-gap timeout unit: one character time, 100 us
`define SHP_RO_UNIT_NS 100000
`define SHP_CLK_NS 10
`define SHP_RO_UNIT_CYC (`SHP_RO_UNIT_NS / `SHP_CLK_NS)
// Serial-mode codes
`define SHP_MODE_TRANSPARENT 2'h0
`define SHP_MODE_FRAMED 2'h1
// Buffer shape
`define SHP_FIFO_DEPTH 32

`endif

/* rtl/shp_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/1ns
module shp_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o,
    // Fill level
    output logic [$clog2(DEPTH):0] count_o
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic ready_r;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire [AW:0] cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

    // Ready is registered so the top output comes from a flop
    assign in_ready_o = ready_r;
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem[rp_r];
    assign count_o = cnt_r;

    // Storage write
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wp_r] <= in_data_i;
        end
    end

    // Pointers and level
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b1;
        end else begin
            if (push) wp_r <= wp_r + AW'(1);
            if (pop) rp_r <= rp_r + AW'(1);
            cnt_r <= cnt_nxt;
            ready_r <= (cnt_nxt != (AW+1)'(DEPTH));
        end
    end
endmodule : shp_fifo

/* rtl/shp_host_port.sv */
/*
 * Host serial port: mode-0 SPI slave carrying unescaped frames, attention
 * line, chip-select pin sleep, and transparent-mode packetization triggers.
 * Assumes the SPI pins are asynchronous and sampled on mclk_i (100 MHz),
 * the master clock at most 3.5 Mb/s, and a radio side on the user ports.
 */
//
// What this block does
// - SPI carries only unescaped framed packets
// - Serial-mode setting ignored while SPI used
// - Full duplex; filler outside frames discarded
// - Output frame may start anytime versus input
// - Full-rate simultaneous receive and transmit
// - Sleep pin peripheral controls pin sleep
// - Else chip select low wakes, high sleeps
// - Sleep while deselected for other slaves
// - Neither peripheral: stay awake always
// - Mode 0: idle low, sample rising
// - Most significant bit shifted first
// - Default transparent; setting selects framed
// - Transparent: UART bytes queued, radio out
// - Packetize after idle gap; zero immediate
// - Command sequence flushes buffered bytes
// - Packetize at 100 buffered bytes
// - Attention low while queue holds data or a byte shifts
// - Data output released while deselected
`timescale 1ns/1ns
`include "shp_defs.svh"
module shp_host_port #(
    parameter int FIFO_W = 9,
    parameter int FIFO_DEPTH = `SHP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // SPI pins
    input wire logic spi_clk_i,
    input wire logic chip_select_low_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    output logic attention_low_o,
    // Sleep pin and configuration
    input wire logic digital_io_eight_i,
    input wire shp_pkg::shp_sleep_cfg_t sleep_cfg_i,
    output logic asleep_o,
    // Interface and serial-mode selection
    input wire logic spi_in_use_i,
    input wire logic [1:0] serial_mode_select_i,
    output logic framed_mode_o,
    // Frames to send to the master
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic [7:0] tx_data_i,
    // Frame bytes received from the master
    output logic rx_valid_o,
    output logic rx_sof_o,
    output logic [7:0] rx_data_o,
    // Transparent UART byte path
    input wire logic uart_valid_i,
    input wire logic [7:0] uart_data_i,
    input wire logic [7:0] idle_gap_timeout_i,
    input wire logic cmd_seq_seen_i,
    output logic packetize_o,
    output logic [6:0] buffered_o
);
    // Synchronised pins
    logic sclk_s;
    logic csel_s;
    logic mosi_s;
    logic sleep_s;
    shp_sync #(.W(4), .INIT(4'b0010)) u_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .d_i({spi_clk_i, chip_select_low_i, spi_mosi_i, digital_io_eight_i}),
        .q_o({sclk_s, csel_s, mosi_s, sleep_s})
    );

    // Edge detection on the clean clock
    logic sclk_d_r;
    wire selected = ~csel_s;
    wire sclk_rise = sclk_s & ~sclk_d_r & selected;
    wire sclk_fall = ~sclk_s & sclk_d_r & selected;

    // Shift state
    logic [2:0] bit_r;
    logic [7:0] rx_sh_r;
    logic [7:0] tx_sh_r;
    logic tx_have_r;
    wire [7:0] rx_byte = {rx_sh_r[6:0], mosi_s};
    wire byte_done = sclk_rise && (bit_r == `SHP_MSB);

    // Output buffer between the radio side and the shifter
    logic [8:0] fq_out;
    logic fq_valid;
    // Send queue fill level is not needed by the shifter
    wire load_byte = byte_done || (sclk_fall && bit_r == 3'h0 && !tx_have_r);
    wire fq_pop = load_byte && fq_valid;
    shp_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_txq (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i({1'b0, tx_data_i}),
        .out_valid_o(fq_valid),
        .out_ready_i(fq_pop),
        .out_data_o(fq_out),
        .count_o()
    );

    // Bit counter and receive shifter; MSB first both ways
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i || !selected) begin
            bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
        end else if (sclk_rise) begin
            bit_r <= bit_r + 3'h1;
            rx_sh_r <= rx_byte;
        end
    end

    // Transmit shifter: filler is zero when nothing valid waits
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            tx_sh_r <= 8'h00;
            tx_have_r <= 1'b0;
        end else if (byte_done) begin
            tx_sh_r <= fq_valid ? fq_out[7:0] : 8'h00;
            tx_have_r <= fq_valid;
        end else if (sclk_fall && bit_r != 3'h0) begin
            tx_sh_r <= {tx_sh_r[6:0], 1'b0};
        end else if (sclk_fall && !tx_have_r && fq_valid) begin
            tx_sh_r <= fq_out[7:0];
            tx_have_r <= 1'b1;
        end
    end

    // Data output and its release
    logic miso_r;
    logic miso_oe_r;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            miso_r <= 1'b0;
            miso_oe_r <= 1'b0;
        end else begin
            miso_r <= tx_sh_r[`SHP_MSB];
            miso_oe_r <= selected;
        end
    end
    assign spi_miso_o = miso_r;
    assign spi_miso_oe_o = miso_oe_r;

    // Attention: low while the send queue holds a byte or a byte is mid-shift, always driven
    logic attn_r;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            attn_r <= 1'b1;
        end else begin
            attn_r <= ~(fq_valid | (tx_have_r & (bit_r != 3'h0)));
        end
    end
    assign attention_low_o = attn_r;

    // Frame hunter on received bytes; filler is dropped
    shp_pkg::shp_rx_state_t st_r;
    shp_pkg::shp_rx_state_t st_nxt;
    logic [15:0] len_r;
    logic [15:0] len_nxt;
    logic emit;
    logic sof;
    always_comb begin
        st_nxt = st_r;
        len_nxt = len_r;
        emit = 1'b0;
        sof = 1'b0;
        case (st_r)
            shp_pkg::SHP_RX_HUNT: begin
                if (rx_byte == `SHP_FRAME_START) begin
                    st_nxt = shp_pkg::SHP_RX_LENH;
                    emit = 1'b1;
                    sof = 1'b1;
                end
            end
            shp_pkg::SHP_RX_LENH: begin
                len_nxt = {rx_byte, 8'h00};
                st_nxt = shp_pkg::SHP_RX_LENL;
                emit = 1'b1;
            end
            shp_pkg::SHP_RX_LENL: begin
                len_nxt = {len_r[15:8], rx_byte} + `SHP_CSUM_LEN;
                st_nxt = shp_pkg::SHP_RX_BODY;
                emit = 1'b1;
            end
            shp_pkg::SHP_RX_BODY: begin
                len_nxt = len_r - 16'h0001;
                emit = 1'b1;
                if (len_r == 16'h0001) begin
                    st_nxt = shp_pkg::SHP_RX_HUNT;
                end
            end
            default: begin
                st_nxt = shp_pkg::SHP_RX_HUNT;
            end
        endcase
    end

    // Frame state and delivered byte
    logic rx_valid_r;
    logic rx_sof_r;
    logic [7:0] rx_data_r;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            st_r <= shp_pkg::SHP_RX_HUNT;
            len_r <= 16'h0000;
            rx_valid_r <= 1'b0;
            rx_sof_r <= 1'b0;
            rx_data_r <= 8'h00;
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= sclk_s;
            rx_valid_r <= byte_done && emit;
            rx_sof_r <= byte_done && sof;
            if (byte_done) begin
                st_r <= st_nxt;
                len_r <= len_nxt;
                rx_data_r <= rx_byte;
            end
        end
    end
    assign rx_valid_o = rx_valid_r;
    assign rx_sof_o = rx_sof_r;
    assign rx_data_o = rx_data_r;

    // Pin sleep source selection
    wire sleep_req = sleep_cfg_i.sleep_pin_periph ? sleep_s :
                     sleep_cfg_i.csel_periph ? csel_s :
                     1'b0;
    logic asleep_r;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            asleep_r <= 1'b0;
        end else begin
            asleep_r <= sleep_cfg_i.pin_sleep_en & sleep_req;
        end
    end
    assign asleep_o = asleep_r;

    // Serial mode: SPI always framed, UART follows setting
    logic framed_r;
    wire uart_framed = (serial_mode_select_i != `SHP_MODE_TRANSPARENT);
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            framed_r <= 1'b0;
        end else begin
            framed_r <= spi_in_use_i | uart_framed;
        end
    end
    assign framed_mode_o = framed_r;

    // Transparent buffer accounting and packetization triggers
    localparam int RO_W = 24;
    logic [6:0] buf_r;
    logic [RO_W-1:0] gap_r;
    logic pkt_r;
    wire transparent = ~framed_r;
    wire take = transparent && uart_valid_i;
    wire [RO_W-1:0] gap_lim = RO_W'(idle_gap_timeout_i) * RO_W'(`SHP_RO_UNIT_CYC);
    wire ro_now = take && idle_gap_timeout_i == `SHP_RO_ZERO;
    wire full_now = take && (buf_r + 7'h01) == `SHP_MAX_PAYLOAD;
    wire gap_now = transparent && buf_r != 7'h00 && !uart_valid_i &&
                   gap_r == gap_lim;
    wire cmd_now = transparent && cmd_seq_seen_i && buf_r != 7'h00;
    wire fire = ro_now || full_now || gap_now || cmd_now;
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            buf_r <= 7'h00;
            gap_r <= '0;
            pkt_r <= 1'b0;
        end else begin
            pkt_r <= fire;
            if (fire) begin
                buf_r <= 7'h00;
            end else if (take) begin
                buf_r <= buf_r + 7'h01;
            end
            if (take || buf_r == 7'h00) begin
                gap_r <= '0;
            end else if (gap_r != gap_lim) begin
                gap_r <= gap_r + RO_W'(1);
            end
        end
    end
    assign packetize_o = pkt_r;
    assign buffered_o = buf_r;

endmodule : shp_host_port

/* rtl/shp_pkg.sv */
/*
 * Types shared by the host serial port block.
 * Assumes shp_defs.svh is available for constants.
 */
package shp_pkg;

    // Frame receive states
    typedef enum logic [3:0] {
        SHP_RX_HUNT = 4'b0001,
        SHP_RX_LENH = 4'b0010,
        SHP_RX_LENL = 4'b0100,
        SHP_RX_BODY = 4'b1000
    } shp_rx_state_t;

    // One byte with a frame-start marker
    typedef struct packed {
        logic sof;
        logic [7:0] data;
    } shp_byte_t;

    // Sleep configuration
    typedef struct packed {
        logic sleep_pin_periph;
        logic csel_periph;
        logic pin_sleep_en;
    } shp_sleep_cfg_t;

endpackage : shp_pkg

/* rtl/shp_sync.sv */
/*
 * Two-flop synchroniser bank for pin inputs.
 * Assumes asynchronous inputs and a single destination clock.
 */
`timescale 1ns/1ns
module shp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // Meta stage feeds only the second stage
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            meta_r <= INIT;
            q_r <= INIT;
        end else begin
            meta_r <= d_i;
            q_r <= meta_r;
        end
    end
    assign q_o = q_r;
endmodule : shp_sync

/* verif/shp_host_port_sva.sv */
/* Checker for the host serial port: SPI pins, sleep, mode and packetize.
   Assumes a bind onto shp_host_port with ports matched by name. */
`timescale 1ns/1ns
module shp_host_port_sva (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // SPI pins
    input wire logic spi_clk_i,
    input wire logic chip_select_low_i,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe_o,
    input wire logic attention_low_o,
    // Sleep
    input wire logic digital_io_eight_i,
    input wire shp_pkg::shp_sleep_cfg_t sleep_cfg_i,
    input wire logic asleep_o,
    // Mode
    input wire logic spi_in_use_i,
    input wire logic [1:0] serial_mode_select_i,
    input wire logic framed_mode_o,
    // Frame paths
    input wire logic tx_valid_i,
    input wire logic tx_ready_o,
    input wire logic rx_valid_o,
    input wire logic rx_sof_o,
    input wire logic [7:0] rx_data_o,
    // Transparent path
    input wire logic uart_valid_i,
    input wire logic [7:0] idle_gap_timeout_i,
    input wire logic cmd_seq_seen_i,
    input wire logic packetize_o,
    input wire logic [6:0] buffered_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    // Selected sleep sources
    wire cs_src = !sleep_cfg_i.sleep_pin_periph && sleep_cfg_i.csel_periph;
    wire pin_src = sleep_cfg_i.sleep_pin_periph && sleep_cfg_i.pin_sleep_en;
    sequence s_push; tx_valid_i && tx_ready_o; endsequence
    sequence s_byte; uart_valid_i && !framed_mode_o; endsequence
    property p_attn; s_push |-> ##2 !attention_low_o; endproperty
    property p_cs_sleep;
        (cs_src && sleep_cfg_i.pin_sleep_en && chip_select_low_i)[*4] |-> asleep_o;
    endproperty
    property p_cs_wake; (cs_src && !chip_select_low_i)[*4] |-> !asleep_o; endproperty
    property p_pin_sleep; (pin_src && digital_io_eight_i)[*4] |-> asleep_o; endproperty
    property p_awake;
        (!sleep_cfg_i.sleep_pin_periph && !sleep_cfg_i.csel_periph)[*3] |-> !asleep_o;
    endproperty
    property p_oe; chip_select_low_i[*4] |-> !spi_miso_oe_o; endproperty
    property p_miso;
        (spi_clk_i && !chip_select_low_i && spi_miso_oe_o)[*7] |-> $stable(spi_miso_o);
    endproperty
    property p_sof; rx_sof_o |-> rx_valid_o && rx_data_o == 8'h7e; endproperty
    property p_mode;
        (!spi_in_use_i && $stable(serial_mode_select_i))[*3]
            |-> framed_mode_o == (serial_mode_select_i != 2'h0);
    endproperty
    property p_ign; spi_in_use_i[*3] |-> $stable(framed_mode_o); endproperty
    property p_full; s_byte and buffered_o == 7'h63 |-> ##[1:2] packetize_o; endproperty
    property p_ro0; s_byte and idle_gap_timeout_i == 8'h00 |-> ##[1:2] packetize_o; endproperty
    property p_cmd;
        cmd_seq_seen_i && !framed_mode_o && buffered_o != 7'h00 |-> ##[1:2] packetize_o;
    endproperty
    a_attn: assert property (p_attn) else $error("attention not low");
    a_cs_sleep: assert property (p_cs_sleep) else $error("no cs sleep");
    a_cs_wake: assert property (p_cs_wake) else $error("asleep while selected");
    a_pin_sleep: assert property (p_pin_sleep) else $error("no pin sleep");
    a_awake: assert property (p_awake) else $error("asleep with no source");
    a_oe: assert property (p_oe) else $error("miso driven while deselected");
    a_miso: assert property (p_miso) else $error("miso moved while clock high");
    a_sof: assert property (p_sof) else $error("bad start marker");
    a_mode: assert property (p_mode) else $error("mode not applied");
    a_ign: assert property (p_ign) else $error("mode changed under spi");
    a_full: assert property (p_full) else $error("no packetize at limit");
    a_ro0: assert property (p_ro0) else $error("no immediate packetize");
    a_cmd: assert property (p_cmd) else $error("no packetize on command");
endmodule : shp_host_port_sva

/* verif/shp_spi_master.sv */
/* Behavioural SPI master facing the host port.
   Assumes the bench calls its tasks; its clock runs only inside transfers. */
`timescale 1ns/1ns
module shp_spi_master (
    // Pins toward the slave
    output logic sclk_o,
    output logic cs_low_o,
    output logic mosi_o,
    // Slave answer
    input wire logic miso_i,
    input wire logic miso_oe_i,
    input wire logic attn_low_i
);
    // Idle clock low, deselected
    initial begin
        sclk_o = 1'b0;
        cs_low_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Select level, off the system clock phase
    task automatic set_cs(input logic v);
        #7 cs_low_o = v;
    endtask : set_cs
    // One byte each way, MSB first, sampled at the rising edge
    task automatic xfer(input logic [7:0] tx, input int gap, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi_o = tx[i];
            #80 sclk_o = 1'b1; // Half bit time fixed at 80 ns
            rx[i] = miso_oe_i ? miso_i : 1'bx;
            #80 sclk_o = 1'b0;
        end
        mosi_o = ~mosi_o; // Stale data is not left on the line
        #(gap);
    endtask : xfer
    // Poll attention before clocking out pending data
    task automatic wait_attn(output logic seen);
        seen = 1'b0;
        for (int i = 0; i < 200 && !seen; i++) begin
            #10 seen = (attn_low_i === 1'b0);
        end
    endtask : wait_attn
endmodule : shp_spi_master

/* verif/test_spi_slave_host_port.sv */
/* Self-checking bench for shp_host_port with a queue-based model.
   Assumes the SPI master model and the checker from verif/. */
`timescale 1ns/1ns
module test_spi_slave_host_port;
    logic mclk = 1'b0, rst_b = 1'b0, digital_io_eight = 1'b0, spi_use = 1'b0;
    logic tx_v = 1'b0, uart_v = 1'b0, cmd_seq = 1'b0, seen, e;
    shp_pkg::shp_sleep_cfg_t cfg = '0;
    logic [1:0] mode_sel = 2'h0;
    logic [7:0] tx_d = 8'h00, uart_d = 8'h00, gap_to = 8'h00, r, b;
    wire sclk, cs_low, mosi, miso, miso_oe, attn, asleep, framed, tx_rdy, rx_v, rx_sof, pkt;
    wire [7:0] rx_d;
    wire [6:0] buffered;
    int n_errors = 0, checks_done = 0, n_pkt = 0, cyc, p0, k;
    logic [7:0] rxq[$], txq[$], misoq[$], mq[$];
    // System clock
    initial begin
        forever #5 mclk = ~mclk;
    end
    shp_spi_master u_mst (.sclk_o(sclk), .cs_low_o(cs_low), .mosi_o(mosi),
        .miso_i(miso), .miso_oe_i(miso_oe), .attn_low_i(attn));
    shp_host_port u_dut (.mclk_i(mclk), .rst_b_i(rst_b), .spi_clk_i(sclk),
        .chip_select_low_i(cs_low), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_o(miso_oe), .attention_low_o(attn), .digital_io_eight_i(digital_io_eight),
        .sleep_cfg_i(cfg), .asleep_o(asleep), .spi_in_use_i(spi_use),
        .serial_mode_select_i(mode_sel), .framed_mode_o(framed), .tx_valid_i(tx_v),
        .tx_ready_o(tx_rdy), .tx_data_i(tx_d), .rx_valid_o(rx_v), .rx_sof_o(rx_sof),
        .rx_data_o(rx_d), .uart_valid_i(uart_v), .uart_data_i(uart_d),
        .idle_gap_timeout_i(gap_to), .cmd_seq_seen_i(cmd_seq), .packetize_o(pkt),
        .buffered_o(buffered));
    // Capture frame bytes and packetize pulses
    always @(posedge mclk) begin
        if (rx_v === 1'b1) rxq.push_back(rx_d);
        if (pkt === 1'b1) n_pkt++;
    end
    task automatic wrap_up;
        $display("Checks done %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic fail(input string what);
        n_errors++;
        $display("Error at %0t: %s timed out", $time, what);
        wrap_up();
    endtask : fail
    // One UART byte per cycle, random data
    task automatic uart_send(input int n);
        for (int i = 0; i < n; i++) begin
            uart_v <= 1'b1;
            uart_d <= 8'($urandom);
            @(posedge mclk);
        end
        uart_v <= 1'b0;
        @(posedge mclk);
    endtask : uart_send
    // Main sequence
    initial begin
        void'($urandom(78461));
        repeat (6) @(posedge mclk);
        chk(attn, 8'h01, "reset attention");
        chk(miso_oe, 8'h00, "reset oe");
        chk(framed, 8'h00, "reset mode");
        rst_b <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            mode_sel <= 2'(m);
            repeat (4) @(posedge mclk);
            chk(framed, 8'(m != 0), "mode");
        end
        uart_send(1);
        chk(buffered, 8'h00, "framed ignores uart");
        mode_sel <= 2'h0;
        repeat (4) @(posedge mclk);
        p0 = n_pkt;
        uart_send(1);
        repeat (2) @(posedge mclk);
        chk(8'(n_pkt - p0), 8'h01, "timeout zero");
        gap_to <= 8'h01;
        uart_send(5);
        chk(buffered, 8'h05, "buffered count");
        for (cyc = 0; cyc < 12000 && pkt !== 1'b1; cyc++) @(negedge mclk);
        chk(8'(cyc >= 9990 && cyc <= 10010), 8'h01, "idle gap");
        if (pkt !== 1'b1) fail("idle gap");
        repeat (2) @(posedge mclk);
        gap_to <= 8'hff;
        p0 = n_pkt;
        uart_send(3);
        cmd_seq <= 1'b1;
        @(posedge mclk);
        cmd_seq <= 1'b0;
        repeat (3) @(posedge mclk);
        chk(8'(n_pkt - p0), 8'h01, "command flush");
        uart_send(99);
        chk(buffered, 8'h63, "below limit");
        uart_send(1);
        repeat (2) @(posedge mclk);
        chk(8'(n_pkt - p0), 8'h02, "payload limit");
        chk(buffered, 8'h00, "emptied");
        for (int i = 0; i < 16; i++) begin
            cfg <= 3'($urandom);
            digital_io_eight <= 1'($urandom);
            u_mst.set_cs(1'($urandom));
            repeat (8) @(posedge mclk);
            e = cfg.csel_periph ? cs_low : 1'b0;
            e = cfg.pin_sleep_en & (cfg.sleep_pin_periph ? digital_io_eight : e);
            chk(asleep, 8'(e), "sleep");
        end
        cfg <= '0;
        u_mst.set_cs(1'b1);
        spi_use <= 1'b1;
        @(posedge mclk);
        mode_sel <= 2'h0;
        repeat (4) @(posedge mclk);
        chk(framed, 8'h01, "mode under spi");
        txq = {8'h7e, 8'h00, 8'h1d};
        repeat (29) txq.push_back(8'($urandom));
        // Delimiter, length 2, two payload bytes, checksum byte
        mq = {8'h7e, 8'h00, 8'h02, 8'($urandom), 8'($urandom), 8'($urandom)};
        for (int i = 0; i < 35; i++) begin
            tx_v <= 1'b1;
            tx_d <= (i < 32) ? txq[i] : 8'h55;
            @(posedge mclk);
        end
        tx_v <= 1'b0;
        @(negedge mclk);
        chk(tx_rdy, 8'h00, "fifo full");
        u_mst.wait_attn(seen);
        if (!seen) fail("attention");
        u_mst.set_cs(1'b0);
        #200;
        for (int i = 0; i < 42; i++) begin
            b = (i < 2) ? 8'hff : (i < 8) ? mq[i - 2] : 8'h00;
            u_mst.xfer(b, $urandom_range(400), r);
            misoq.push_back(r);
        end
        k = 0;
        while (k < 9 && misoq[k] === 8'h00) k++;
        for (int j = 0; j < 33; j++) begin
            chk(misoq[k + j], (j < 32) ? txq[j] : 8'h00, "miso byte");
        end
        chk(attn, 8'h01, "attention released");
        chk(8'(rxq.size()), 8'h06, "rx count");
        foreach (mq[j]) chk(rxq[j], mq[j], "rx byte");
        u_mst.set_cs(1'b1);
        repeat (8) @(posedge mclk);
        chk(miso_oe, 8'h00, "released");
        wrap_up();
    end
endmodule : test_spi_slave_host_port
bind shp_host_port shp_host_port_sva u_sva (.*);
